// [src/seebss_pkg.sv]
// Shared constants for the serial memory bus slave
`default_nettype none
package seebss_pkg;
  localparam int CLK_FREQ_HZ = 25000000;
  // Glitch suppression width, ns
  localparam int INPUT_GLITCH_FILTER_WIDTH_NS = 50;
  localparam int GLITCH_CYC_RAW = (INPUT_GLITCH_FILTER_WIDTH_NS * 25) / 1000;
  // A spike can straddle RAW+1 sampling edges, so one more sample is demanded
  localparam int GLITCH_CYC = GLITCH_CYC_RAW + 2;
  // Output hold after falling clock, ns (least time, rounds up)
  localparam int OUT_HOLD_NS = 300;
  localparam int OUT_HOLD_CYC = (OUT_HOLD_NS * 25 + 999) / 1000;
  // Write cycle time, ms (longest time, rounds down)
  localparam int WRITE_CYCLE_MS = 5;
  localparam int WRITE_CYCLE_CYC = (WRITE_CYCLE_MS * 25000);
  localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
  localparam logic [14:0] ADDR_RESET = 15'h0000;
  localparam logic [14:0] ADDR_LAST = 15'h7fff;
  localparam logic [5:0] PAGE_BYTES_MASK = 6'h3f;
  typedef enum logic [2:0] {
    SEEBSS_IDLE, SEEBSS_CTRL, SEEBSS_ADDR_HI, SEEBSS_ADDR_LO, SEEBSS_WDATA,
    SEEBSS_RDATA, SEEBSS_IGNORE
  } seebss_state_t;
endpackage
`default_nettype wire

// [src/seebss_filter.sv]
// Two-flop synchroniser followed by a stable-count glitch filter
`default_nettype none
module seebss_filter #(
  parameter int STABLE_CYC = 2,
  parameter bit INIT       = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic raw_in,
  output logic      clean_q
);
  logic       s1_q;
  logic       s2_q;
  logic [7:0] cnt_q;

  if (STABLE_CYC < 1 || STABLE_CYC > 255) begin : g_bad_stable
    $error("STABLE_CYC out of range");
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= INIT;
      s2_q <= INIT;
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
    end
  end

  // Pulses shorter than the count never reach the output
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clean_q <= INIT;
      cnt_q   <= 8'h00;
    end else if (s2_q == clean_q) begin
      cnt_q <= 8'h00;
    end else if (cnt_q >= 8'(STABLE_CYC - 1)) begin
      clean_q <= s2_q;
      cnt_q   <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule
`default_nettype wire

// [src/seebss_top.sv]
// Two-wire serial memory slave with chip select and write protect
// Behaviour
// [R01] Respond only when straps match select bits
// [R02] Eight devices share bus by strap combinations
// [R03] Unconnected straps read as low
// [R04] Data changes only while clock low
// [R05] Data edge during clock high is START/STOP
// [R06] Floating write protect counts as low
// [R07] Protect low allows reading and writing everywhere
// [R08] Protect high blocks every array write
// [R09] Protect high leaves reads unchanged
// [R10] Self-timed write finishes within 5 ms
// [R11] Ignore glitches up to 50 ns
// [R12] Hold data 300 ns after falling clock
// [R13] Control byte carries type 1010, select, direction
// [R14] Direction one reads, zero writes
// [R15] Sample write protect at the ending STOP
// [R16] No acknowledge while programming runs
// [R17] Only pull data low or release it
`default_nettype none
module seebss_top
  import seebss_pkg::*;
#(
  parameter int WRITE_CYC  = WRITE_CYCLE_CYC,
  parameter int DEPTH      = 32768,
  parameter int PAGE_BYTES = 64
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic chip_select_strap_0,
  input  wire logic chip_select_strap_1,
  input  wire logic chip_select_strap_2,
  input  wire logic write_protect,
  output logic      busy_q
);
  if (DEPTH != 32768 || PAGE_BYTES != 64) begin : g_bad_size
    $error("Only 32K x 8 with 64-byte pages");
  end
  if (WRITE_CYC < 1 || WRITE_CYC > WRITE_CYCLE_CYC) begin : g_bad_wcyc
    $error("WRITE_CYC out of range");
  end

  // ==========================================================
  // Input conditioning
  logic scl_f;
  logic sda_f;
  logic [3:0] strap_s1_q;
  logic [3:0] strap_s2_q;

  // [R11] Glitch filters
  seebss_filter #(.STABLE_CYC(GLITCH_CYC), .INIT(1'b1)) u_scl_filt (
    .clk(clk), .rst_n(rst_n), .raw_in(scl_in), .clean_q(scl_f));
  seebss_filter #(.STABLE_CYC(GLITCH_CYC), .INIT(1'b1)) u_sda_filt (
    .clk(clk), .rst_n(rst_n), .raw_in(sda_in), .clean_q(sda_f));

  // [R03] Straps and protect pin rest low when floating
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_s1_q <= 4'h0;
      strap_s2_q <= 4'h0;
    end else begin
      strap_s1_q <= {write_protect, chip_select_strap_2, chip_select_strap_1,
                     chip_select_strap_0};
      strap_s2_q <= strap_s1_q;
    end
  end

  logic       wp_s;
  logic [2:0] straps;
  // [R06] Protect is a plain level, low by default
  assign wp_s   = strap_s2_q[3];
  assign straps = strap_s2_q[2:0];

  logic scl_d1_q;
  logic sda_d1_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_d1_q <= scl_f;
      sda_d1_q <= sda_f;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  assign scl_rise   = scl_f & ~scl_d1_q;
  assign scl_fall   = ~scl_f & scl_d1_q;
  // [R05] Data edges under high clock are bus conditions
  assign start_cond = scl_f & scl_d1_q & sda_d1_q & ~sda_f;
  assign stop_cond  = scl_f & scl_d1_q & ~sda_d1_q & sda_f;

  // ==========================================================
  // Byte engine
  seebss_state_t state_q;
  logic [3:0]  bit_q;
  logic [7:0]  shift_q;
  logic        ack_phase_q;
  logic        rd_q;
  logic        wr_pending_q;
  logic [14:0] addr_q;
  logic [7:0]  rdata;
  logic [7:0]  mem [DEPTH];
  logic [7:0]  page_buf [PAGE_BYTES];
  logic [14:0] page_base_q;
  logic [6:0]  page_cnt_q;
  logic        ack_drive_q;
  logic        master_nack_q;
  logic        byte_done;
  logic [7:0]  byte_in;

  assign rdata     = mem[addr_q];
  assign byte_done = scl_rise & ~ack_phase_q & (bit_q == 4'd7);
  assign byte_in   = {shift_q[6:0], sda_f};

  // Bits are taken on the rising clock edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q      <= SEEBSS_IDLE;
      bit_q        <= 4'd0;
      shift_q      <= 8'h00;
      ack_phase_q  <= 1'b0;
      rd_q         <= 1'b0;
      ack_drive_q  <= 1'b0;
      master_nack_q <= 1'b0;
    end else if (start_cond) begin
      state_q     <= SEEBSS_CTRL;
      bit_q       <= 4'd0;
      ack_phase_q <= 1'b0;
      ack_drive_q <= 1'b0;
    end else if (stop_cond) begin
      state_q     <= SEEBSS_IDLE;
      ack_phase_q <= 1'b0;
      ack_drive_q <= 1'b0;
    end else if (state_q != SEEBSS_IDLE && state_q != SEEBSS_IGNORE) begin
      if (scl_rise && !ack_phase_q) begin
        shift_q <= byte_in;
        bit_q   <= bit_q + 4'd1;
      end
      if (scl_rise && ack_phase_q) begin
        master_nack_q <= sda_f;
        // Ninth clock seen: the next fall ends the ack slot
        bit_q         <= 4'd1;
      end
      if (byte_done) begin
        ack_phase_q <= 1'b1;
        bit_q       <= 4'd0;
        case (state_q)
          SEEBSS_CTRL: begin
            // [R01] [R02] [R13] Type code and strap match
            // [R16] Silent while programming
            if (byte_in[7:4] == DEV_TYPE_CODE && byte_in[3:1] == straps && !busy_q) begin
              ack_drive_q <= 1'b1;
              // [R14] Direction bit
              rd_q        <= byte_in[0];
            end else begin
              state_q <= SEEBSS_IGNORE;
            end
          end
          SEEBSS_ADDR_HI, SEEBSS_ADDR_LO, SEEBSS_WDATA: ack_drive_q <= 1'b1;
          default: ack_drive_q <= 1'b0;
        endcase
      end
      if (scl_fall && ack_phase_q && bit_q == 4'd1) begin
        ack_phase_q <= 1'b0;
        ack_drive_q <= 1'b0;
        bit_q       <= 4'd0;
        case (state_q)
          SEEBSS_CTRL:    state_q <= rd_q ? SEEBSS_RDATA : SEEBSS_ADDR_HI;
          SEEBSS_ADDR_HI: state_q <= SEEBSS_ADDR_LO;
          SEEBSS_ADDR_LO: state_q <= SEEBSS_WDATA;
          SEEBSS_WDATA:   state_q <= SEEBSS_WDATA;
          SEEBSS_RDATA:   state_q <= master_nack_q ? SEEBSS_IGNORE : SEEBSS_RDATA;
          default:        state_q <= SEEBSS_IGNORE;
        endcase
      end
    end
  end

  // ==========================================================
  // Address pointer and page buffer
  // [R07] Whole 15-bit range is reachable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_q       <= ADDR_RESET;
      page_base_q  <= ADDR_RESET;
      page_cnt_q   <= 7'd0;
      wr_pending_q <= 1'b0;
    end else begin
      if (start_cond) begin
        wr_pending_q <= 1'b0;
      end
      if (byte_done && !busy_q) begin
        case (state_q)
          SEEBSS_ADDR_HI: addr_q[14:8] <= byte_in[6:0];
          SEEBSS_ADDR_LO: begin
            addr_q[7:0] <= byte_in;
            page_cnt_q  <= 7'd0;
          end
          SEEBSS_WDATA: begin
            if (page_cnt_q == 7'd0) begin
              page_base_q <= addr_q;
            end
            page_buf[addr_q[5:0]] <= byte_in;
            if (page_cnt_q != 7'(PAGE_BYTES)) begin
              page_cnt_q <= page_cnt_q + 7'd1;
            end
            // Page roll-over: only the low six bits advance
            addr_q[5:0]  <= addr_q[5:0] + 6'd1;
            wr_pending_q <= 1'b1;
          end
          default: ;
        endcase
      end
      // [R09] Reads advance regardless of protect
      if (state_q == SEEBSS_RDATA && scl_fall && ack_phase_q && bit_q == 4'd1) begin
        addr_q <= (addr_q == ADDR_LAST) ? ADDR_RESET : addr_q + 15'd1;
      end
      if (stop_cond) begin
        wr_pending_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Self-timed write cycle
  logic [17:0] wc_cnt_q;
  logic [6:0]  cp_idx_q;
  logic [6:0]  cp_len_q;
  logic        cp_active_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q      <= 1'b0;
      wc_cnt_q    <= 18'h00000;
      cp_idx_q    <= 7'd0;
      cp_len_q    <= 7'd0;
      cp_active_q <= 1'b0;
    // [R15] [R08] Protect sampled at STOP decides the write
    end else if (stop_cond && wr_pending_q && !busy_q && !wp_s) begin
      busy_q      <= 1'b1;
      wc_cnt_q    <= 18'(WRITE_CYC - 1);
      cp_idx_q    <= 7'd0;
      cp_len_q    <= page_cnt_q;
      cp_active_q <= 1'b1;
    end else if (busy_q) begin
      if (cp_active_q) begin
        mem[{page_base_q[14:6], page_base_q[5:0] + cp_idx_q[5:0]}] <=
          page_buf[page_base_q[5:0] + cp_idx_q[5:0]];
        cp_idx_q <= cp_idx_q + 7'd1;
        if (cp_idx_q + 7'd1 >= cp_len_q) begin
          cp_active_q <= 1'b0;
        end
      end
      // [R10] Ends within the write cycle limit
      if (wc_cnt_q == 18'h00000) begin
        busy_q <= 1'b0;
      end else begin
        wc_cnt_q <= wc_cnt_q - 18'h00001;
      end
    end
  end

  // ==========================================================
  // Data line driver
  logic       drive_low_q;
  logic [3:0] hold_q;
  logic       want_low;
  // Read bits shift out MSB first; high bits release the line
  assign want_low = ack_drive_q |
                    (state_q == SEEBSS_RDATA && !ack_phase_q && !rdata[3'(7 - bit_q)]);

  // [R12] [R04] New level applied only after hold delay in clock low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_q      <= 4'h0;
      drive_low_q <= 1'b0;
    end else if (start_cond || stop_cond) begin
      hold_q      <= 4'h0;
      drive_low_q <= 1'b0;
    end else if (scl_fall) begin
      hold_q <= 4'(OUT_HOLD_CYC);
    end else if (hold_q != 4'h0) begin
      hold_q <= hold_q - 4'h1;
      if (hold_q == 4'h1 && !scl_f) begin
        drive_low_q <= want_low;
      end
    end
  end

  // [R17] Open drain: output level always low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe  <= drive_low_q;
    end
  end
endmodule
`default_nettype wire

// [sim/seebss_chk.sv]
// Assertion checker for the serial memory bus slave
`default_nettype none
module seebss_chk #(
  parameter int WRITE_CYC = 200
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic sda_out,
  input  wire logic sda_oe,
  input  wire logic chip_select_strap_0,
  input  wire logic chip_select_strap_1,
  input  wire logic chip_select_strap_2,
  input  wire logic write_protect,
  input  wire logic busy_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==================================================
  // Checks
  int busy_cnt_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Counts sampled busy cycles; cleared when idle
  always_ff @(posedge clk) begin
    busy_cnt_q <= (rst_n && busy_q) ? busy_cnt_q + 1 : 0;
  end
  a_never_high: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  a_hold_fall: assert property ($fell(scl_in) |=> $stable(sda_oe)[*8])
    else $error("data changed too soon after clock fall");
  a_pull_clk_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data pulled while clock high");
  a_release_clk_low: assert property ($fell(sda_oe) |-> !scl_in)
    else $error("data released while clock high");
  a_quiet_busy: assert property (busy_q |-> !sda_oe)
    else $error("acknowledge during write cycle");
  a_busy_bound: assert property (busy_q |-> busy_cnt_q < WRITE_CYC + 2)
    else $error("write cycle too long");
  a_busy_full: assert property ($fell(busy_q) |-> busy_cnt_q >= WRITE_CYC - 1)
    else $error("write cycle cut short");
  a_busy_cause: assert property ($rose(busy_q) |-> scl_in && sda_in && !write_protect)
    else $error("write cycle without stop or while protected");
  c_ack: cover property ($rose(sda_oe));
  c_busy: cover property ($rose(busy_q));
  c_done: cover property ($fell(busy_q));
endmodule
bind seebss_top seebss_chk #(.WRITE_CYC(WRITE_CYC)) u_chk (
  .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .chip_select_strap_0(chip_select_strap_0),
  .chip_select_strap_1(chip_select_strap_1), .chip_select_strap_2(chip_select_strap_2),
  .write_protect(write_protect), .busy_q(busy_q));
`default_nettype wire

// [sim/seebss_master.sv]
// Bus master model driving the serial clock and data line
`default_nettype none
module seebss_master (
  input  wire logic clk,
  input  wire logic sda_wire,
  output var logic  scl,
  output var logic  sda_drv
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==================================================
  // Bus phases
  logic glitch = 1'b0;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Low phase is long: the device holds data 320 ns past each fall
  // data moves mid-low
  task automatic bit_io(input logic b, output logic r);
    wt(12);
    sda_drv = b;
    wt(8);
    scl = glitch;
    wt(1);
    scl = 1'b0;
    wt(3);
    scl = 1'b1;
    wt(4);
    r = sda_wire;
    wt(4);
    scl = 1'b0;
  endtask
  // start is (1,0), stop is (0,1)
  task automatic cond(input logic a, input logic b);
    wt(12);
    sda_drv = a;
    wt(12);
    scl = 1'b1;
    wt(8);
    sda_drv = b;
    wt(16);
    scl = !a;
  endtask
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(last, ack);
  endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Testbench for the serial memory bus slave
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import seebss_pkg::*;
  // ==================================================
  // Harness
  localparam int WCYC = 600;
  logic       clk = 1'b0;
  logic       rst_n, sda_oe, sda_out, busy_q, scl, sda_drv, sda_wire, wp;
  logic [2:0] strap;
  int         n_errors = 0;
  int         check_count = 0;
  always #20 clk = ~clk;
  // Pull-up: device can only pull low
  assign sda_wire = sda_drv & (sda_oe ? sda_out : 1'b1);
  seebss_master mst (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));
  seebss_top #(.WRITE_CYC(WCYC)) uut (.clk(clk), .rst_n(rst_n), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_strap_0(strap[0]),
    .chip_select_strap_1(strap[1]), .chip_select_strap_2(strap[2]),
    .write_protect(wp), .busy_q(busy_q));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ctrl(input logic [7:0] c, output logic ack);
    logic [7:0] q;
    mst.cond(1'b1, 1'b0);
    mst.xfer(c, 1'b1, q, ack);
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic [7:0] b [3];
    logic       k;
    b = '{{1'b0, a[14:8]}, a[7:0], d};
    ctrl({DEV_TYPE_CODE, strap, 1'b0}, nak);
    foreach (b[i]) begin
      mst.xfer(b[i], 1'b1, q, k);
      nak = nak | k;
    end
    mst.cond(1'b0, 1'b1);
  endtask
  task automatic rd(input logic [14:0] a, output logic [7:0] q);
    logic k;
    ctrl({DEV_TYPE_CODE, strap, 1'b0}, k);
    mst.xfer({1'b0, a[14:8]}, 1'b1, q, k);
    mst.xfer(a[7:0], 1'b1, q, k);
    ctrl({DEV_TYPE_CODE, strap, 1'b1}, k);
    mst.xfer(8'hff, 1'b1, q, k);
    mst.cond(1'b0, 1'b1);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < WCYC + 200 && busy_q !== 1'b0; i++) @(negedge clk);
    chk("busy_end", 8'h00, {7'h00, busy_q});
  endtask
  // ==================================================
  // Scenarios
  task automatic t_select();
    logic       k;
    logic [2:0] sv [2];
    sv = '{3'h0, 3'h5};
    foreach (sv[j]) begin
      strap = sv[j];
      for (int c = 0; c < 8; c++) begin
        ctrl({DEV_TYPE_CODE, c[2:0], 1'b0}, k);
        mst.cond(1'b0, 1'b1);
        chk("ack_select", {7'h00, c[2:0] != strap}, {7'h00, k});
      end
    end
    ctrl({4'hb, strap, 1'b0}, k);
    mst.cond(1'b0, 1'b1);
    chk("ack_bad_type", 8'h01, {7'h00, k});
    $display("test select done");
  endtask
  task automatic t_write();
    logic       k;
    logic [7:0] q;
    wr(15'h7fff, 8'h5a, k);
    chk("wr_ack", 8'h00, {7'h00, k});
    wp = 1'b1;
    chk("busy_start", 8'h01, {7'h00, busy_q});
    ctrl({DEV_TYPE_CODE, strap, 1'b0}, k);
    mst.cond(1'b0, 1'b1);
    chk("ack_while_busy", 8'h01, {7'h00, k});
    wait_idle();
    rd(15'h7fff, q);
    chk("rd_back", 8'h5a, q);
    $display("test write done");
  endtask
  task automatic t_protect();
    logic       k;
    logic [7:0] q;
    wp = 1'b1;
    wr(15'h7fff, 8'ha5, k);
    chk("wp_ack", 8'h00, {7'h00, k});
    chk("wp_no_busy", 8'h00, {7'h00, busy_q});
    rd(15'h7fff, q);
    chk("wp_rd", 8'h5a, q);
    wp = 1'b0;
    $display("test protect done");
  endtask
  task automatic t_glitch();
    logic       k;
    logic [7:0] q;
    mst.glitch = 1'b1;
    wr(15'h0000, 8'h3c, k);
    wait_idle();
    rd(15'h0000, q);
    mst.glitch = 1'b0;
    chk("glitch_ack", 8'h00, {7'h00, k});
    chk("glitch_rd", 8'h3c, q);
    $display("test glitch done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    strap = 3'h0;
    wp = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    t_select();
    t_write();
    t_protect();
    t_glitch();
    complete_run();
  end
  // Whole run needs roughly 0.65 ms of bus traffic
  initial begin
    #3ms;
    n_errors++;
    $display("BAD watchdog expected done seen timeout");
    complete_run();
  end
endmodule
`default_nettype wire
